//--- common/adc_ctrl_pkg.sv
// Package holding register offsets, field positions and encodings of the result and trigger block.
package adc_ctrl_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_RESULT_LOW   = 8'h78;
    localparam logic [7:0] OFS_RESULT_HIGH  = 8'h79;
    localparam logic [7:0] OFS_CTRL_A       = 8'h7a;
    localparam logic [7:0] OFS_CTRL_B       = 8'h7b;
    localparam logic [7:0] OFS_CHANNEL_SEL  = 8'h7c;
    localparam logic [7:0] OFS_PIN_DISABLE  = 8'h7e;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int         CTRL_A_ENABLE_BIT  = 7;
    localparam int         CTRL_A_AUTO_BIT    = 5;
    localparam int         CTRL_A_DONE_BIT    = 4;
    localparam int         CTRL_B_CMP_MUX_BIT = 6;
    localparam int         CHSEL_LEFT_BIT     = 5;
    localparam logic [7:0] CTRL_B_WMASK       = 8'h47;
    localparam logic [7:0] CTRL_A_WMASK       = 8'ha0;
    localparam logic [7:0] CHSEL_WMASK        = 8'h3f;
    localparam logic [7:0] RESET_BYTE         = 8'h00;
    localparam logic [9:0] RESET_RESULT       = 10'h000;
    localparam int         RESULT_W           = 10;
    localparam int         LEFT_PAD_W         = 6;
    localparam logic [4:0] DIFF_FIRST_CODE    = 5'h08;
    localparam logic [4:0] DIFF_LAST_CODE     = 5'h1d;

    // ------------------------------------------------------------------
    // Trigger source codes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        TRIG_FREE_RUN   = 3'h0,
        TRIG_COMPARATOR = 3'h1,
        TRIG_EXT_INT0   = 3'h2,
        TRIG_T0_CMP_A   = 3'h3,
        TRIG_T0_OVF     = 3'h4,
        TRIG_T1_CMP_B   = 3'h5,
        TRIG_T1_OVF     = 3'h6,
        TRIG_T1_CAPTURE = 3'h7
    } trig_src_t;

    // Lock state of the result pair, Gray coded.
    typedef enum logic [1:0] {
        LOCK_OPEN = 2'h0,
        LOCK_HELD = 2'h1
    } lock_state_t;

endpackage

//--- hw/adc_result_and_trigger_ctrl.sv
// Result pair, alignment, auto-trigger selection, comparator mux and pin input disables.
//
// Operation
// - Result is a 16-bit read-only pair, low byte at base, high at base plus one.
// - Each finished conversion loads its result into the pair, except while the pair is locked; the code also skips the load while the converter is disabled.
// - Differential channel selection gives two's complement result, else unsigned.
// - Reading low byte locks the pair from the next cycle until high byte is read.
// - Alignment clear puts result in bits 9..0, zeros above.
// - Alignment set puts result in bits 15..6.
// - Alignment change shows on readable pair at once.
// - Mux enable with converter off routes channel mux to comparator negative input.
// - Trigger source field has no effect unless auto-trigger enable is set.
// - With auto-trigger on, each rising edge of selected trigger starts conversion.
// - Trigger comes from rising edge of selected interrupt flag, not level.
// - Switching from clear source to set source makes an edge and may start.
// - Switching to free-running code makes no trigger event.
// - Trigger codes: free run, comparator, int0, t0 cmpA, t0 ovf, t1 cmpB, ovf, capture.
// - Converter enable turns converter on; clearing it aborts a running conversion.
// - Disable bit set turns pin buffer off and pin input reads zero.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module adc_result_and_trigger_ctrl
    import adc_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rstn_i,
    // Register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_write_i,
    input  wire logic        reg_read_i,
    output logic      [7:0]  reg_rdata_o,
    // Conversion core
    input  wire logic        conv_done_i,
    input  wire logic [9:0]  conv_result_i,
    input  wire logic        conv_busy_i,
    output logic             conv_start_o,
    output logic             conv_abort_o,
    output logic             converter_enable_o,
    // Trigger flags from other peripherals
    input  wire logic [6:0]  trigger_flags_i,
    // Comparator negative input routing
    output logic             cmp_neg_from_mux_o,
    // Analog pins
    input  wire logic [7:0]  pin_raw_i,
    output logic [7:0]       pin_buffer_off_o,
    output logic [7:0]       pin_value_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [9:0]  result_ff,   nxt_result;
    logic        done_ff,     nxt_done;
    logic        enable_ff,   nxt_enable;
    logic        auto_ff,     nxt_auto;
    logic        cmp_mux_ff,  nxt_cmp_mux;
    logic [2:0]  trig_sel_ff, nxt_trig_sel;
    logic [5:0]  chsel_ff,    nxt_chsel;
    logic [7:0]  pin_off_ff,  nxt_pin_off;
    logic        trig_lvl_ff, nxt_trig_lvl;
    lock_state_t lock_ff,     nxt_lock;
    logic [7:0]  rdata_ff,    nxt_rdata;
    logic        start_ff,    nxt_start;
    logic        abort_ff,    nxt_abort;
    logic        cmp_out_ff,  nxt_cmp_out;
    logic [7:0]  pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_val_ff, nxt_pin_val;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic wr_hit(input logic [7:0] ofs);
        return reg_write_i && (reg_addr_i == ofs);
    endfunction

    function automatic logic rd_hit(input logic [7:0] ofs);
        return reg_read_i && (reg_addr_i == ofs);
    endfunction

    // Selected flag level; free running follows the done flag.
    function automatic logic trig_level(input logic [2:0] sel, input logic [6:0] flags,
                                        input logic done);
        logic lvl;
        lvl = done;
        if (sel != TRIG_FREE_RUN) begin
            lvl = flags[sel - 3'h1];
        end
        return lvl;
    endfunction

    // ------------------------------------------------------------------
    // Result formatting
    // ------------------------------------------------------------------
    logic        left_align;
    logic [15:0] result_pair;
    logic        is_diff;

    always_comb begin
        left_align = chsel_ff[CHSEL_LEFT_BIT];
        // the core delivers two's complement on differential codes; kept as is.
        is_diff    = (chsel_ff[4:0] >= DIFF_FIRST_CODE) && (chsel_ff[4:0] <= DIFF_LAST_CODE);
        // Formatting is combinational off the held value, so alignment acts at once.
        if (left_align) begin
            result_pair = {result_ff, {LEFT_PAD_W{1'b0}}};
        end else begin
            result_pair = {{LEFT_PAD_W{1'b0}}, result_ff};
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic trig_now;
    logic trig_edge;

    always_comb begin
        nxt_result   = result_ff;
        nxt_done     = done_ff;
        nxt_enable   = enable_ff;
        nxt_auto     = auto_ff;
        nxt_cmp_mux  = cmp_mux_ff;
        nxt_trig_sel = trig_sel_ff;
        nxt_chsel    = chsel_ff;
        nxt_pin_off  = pin_off_ff;
        nxt_lock     = lock_ff;
        nxt_rdata    = RESET_BYTE;
        nxt_start    = 1'b0;
        nxt_abort    = 1'b0;
        nxt_cmp_out  = enable_ff ? 1'b0 : cmp_mux_ff;

        // Register writes.
        if (wr_hit(OFS_CTRL_A)) begin
            nxt_enable = reg_wdata_i[CTRL_A_ENABLE_BIT];
            nxt_auto   = reg_wdata_i[CTRL_A_AUTO_BIT];
            if (reg_wdata_i[CTRL_A_DONE_BIT]) begin
                nxt_done = 1'b0;
            end
            if (enable_ff && !reg_wdata_i[CTRL_A_ENABLE_BIT] && conv_busy_i) begin
                nxt_abort = 1'b1;
            end
        end
        if (wr_hit(OFS_CTRL_B)) begin
            nxt_cmp_mux  = reg_wdata_i[CTRL_B_CMP_MUX_BIT];
            nxt_trig_sel = reg_wdata_i[2:0];
        end
        if (wr_hit(OFS_CHANNEL_SEL)) begin
            nxt_chsel = reg_wdata_i[5:0];
        end
        if (wr_hit(OFS_PIN_DISABLE)) begin
            nxt_pin_off = reg_wdata_i;
        end

        // Lock protocol: low read closes, high read opens.
        if (rd_hit(OFS_RESULT_LOW)) begin
            nxt_lock = LOCK_HELD;
        end
        if (rd_hit(OFS_RESULT_HIGH)) begin
            nxt_lock = LOCK_OPEN;
        end

        // Completion: with the converter enabled the flag sets and wins over a clear.
        if (conv_done_i && enable_ff) begin
            nxt_done = 1'b1;
            if (lock_ff == LOCK_OPEN) begin
                nxt_result = conv_result_i;
            end
        end

        // Trigger edge on the selected flag.
        trig_now     = trig_level(nxt_trig_sel, trigger_flags_i, nxt_done);
        trig_edge    = trig_now && !trig_lvl_ff;
        // Switching into free running must never fire, even from a low level: the edge is
        // masked and the stored level is held high so a set done flag cannot fire next cycle.
        if (nxt_trig_sel == TRIG_FREE_RUN && trig_sel_ff != TRIG_FREE_RUN) begin
            trig_now  = 1'b1;
            trig_edge = 1'b0;
        end
        nxt_trig_lvl = trig_now;
        if (auto_ff && enable_ff && trig_edge) begin
            nxt_start = 1'b1;
        end

        // Read data.
        if (reg_read_i) begin
            case (reg_addr_i)
                OFS_RESULT_LOW:  nxt_rdata = result_pair[7:0];
                OFS_RESULT_HIGH: nxt_rdata = result_pair[15:8];
                OFS_CTRL_A:      nxt_rdata = {enable_ff, conv_busy_i, auto_ff, done_ff, 4'h0};
                OFS_CTRL_B:      nxt_rdata = {1'b0, cmp_mux_ff, 3'h0, trig_sel_ff};
                OFS_CHANNEL_SEL: nxt_rdata = {2'h0, chsel_ff};
                OFS_PIN_DISABLE: nxt_rdata = pin_off_ff;
                default:         nxt_rdata = RESET_BYTE;
            endcase
        end

        // Pin input: accepted once the second and third stages agree.
        nxt_pin_val = pin_val_ff;
        for (int i = 0; i < 8; i++) begin
            if (pin_s2_ff[i] == pin_s3_ff[i]) begin
                nxt_pin_val[i] = pin_s3_ff[i];
            end
            if (pin_off_ff[i]) begin
                nxt_pin_val[i] = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rstn_i) begin
            result_ff   <= RESET_RESULT;
            done_ff     <= 1'b0;
            enable_ff   <= 1'b0;
            auto_ff     <= 1'b0;
            cmp_mux_ff  <= 1'b0;
            trig_sel_ff <= TRIG_FREE_RUN;
            chsel_ff    <= 6'h00;
            pin_off_ff  <= RESET_BYTE;
            trig_lvl_ff <= 1'b0;
            lock_ff     <= LOCK_OPEN;
            rdata_ff    <= RESET_BYTE;
            start_ff    <= 1'b0;
            abort_ff    <= 1'b0;
            cmp_out_ff  <= 1'b0;
            pin_s1_ff   <= RESET_BYTE;
            pin_s2_ff   <= RESET_BYTE;
            pin_s3_ff   <= RESET_BYTE;
            pin_val_ff  <= RESET_BYTE;
        end else begin
            result_ff   <= nxt_result;
            done_ff     <= nxt_done;
            enable_ff   <= nxt_enable;
            auto_ff     <= nxt_auto;
            cmp_mux_ff  <= nxt_cmp_mux;
            trig_sel_ff <= nxt_trig_sel;
            chsel_ff    <= nxt_chsel;
            pin_off_ff  <= nxt_pin_off;
            trig_lvl_ff <= nxt_trig_lvl;
            lock_ff     <= nxt_lock;
            rdata_ff    <= nxt_rdata;
            start_ff    <= nxt_start;
            abort_ff    <= nxt_abort;
            cmp_out_ff  <= nxt_cmp_out;
            pin_s1_ff   <= pin_raw_i;
            pin_s2_ff   <= pin_s1_ff;
            pin_s3_ff   <= pin_s2_ff;
            pin_val_ff  <= nxt_pin_val;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata_o        = rdata_ff;
    assign conv_start_o       = start_ff;
    assign conv_abort_o       = abort_ff;
    assign converter_enable_o = enable_ff;
    assign cmp_neg_from_mux_o = cmp_out_ff;
    assign pin_buffer_off_o   = pin_off_ff;
    assign pin_value_o        = pin_val_ff;

endmodule

//--- bench/adc_ctrl_properties.sv
// Port-level assertions for the result and trigger block.
`timescale 1ns/1ps
module adc_ctrl_properties
    import adc_ctrl_pkg::*;
(
    input wire logic       core_clk_i,
    input wire logic       rstn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_write_i,
    input wire logic       reg_read_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       conv_busy_i,
    input wire logic       conv_start_o,
    input wire logic       conv_abort_o,
    input wire logic       converter_enable_o,
    input wire logic       cmp_neg_from_mux_o,
    input wire logic [7:0] pin_buffer_off_o,
    input wire logic [7:0] pin_value_o
);
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    sequence s_ctrl_a_wr;
        reg_write_i && reg_addr_i == OFS_CTRL_A;
    endsequence
    a_rdata_idle_zero: assert property (!$past(reg_read_i) |-> reg_rdata_o == 8'h00)
        else $error("read data not zero outside answer cycle");
    a_ctrl_b_reserved: assert property ($past(reg_read_i && reg_addr_i == OFS_CTRL_B)
        |-> (reg_rdata_o & ~CTRL_B_WMASK) == 8'h00) else $error("reserved bits read one");
    a_enable_on_write: assert property ((s_ctrl_a_wr ##0 reg_wdata_i[7])
        |-> ##[1:2] converter_enable_o) else $error("enable write not taken");
    a_abort_on_clear: assert property ((s_ctrl_a_wr ##0 !reg_wdata_i[7] && converter_enable_o
        && conv_busy_i) |-> ##[1:2] conv_abort_o) else $error("no abort on disable");
    a_abort_needs_busy: assert property (conv_abort_o |-> $past(conv_busy_i))
        else $error("abort without running conversion");
    a_start_single: assert property (conv_start_o |=> !conv_start_o)
        else $error("start held for two cycles");
    a_start_needs_enable: assert property (conv_start_o |-> $past(converter_enable_o))
        else $error("start while converter off");
    a_mux_off_enabled: assert property (converter_enable_o && $past(converter_enable_o)
        |-> !cmp_neg_from_mux_o) else $error("mux routed while converter on");
    a_pin_forced_zero: assert property ((pin_value_o & pin_buffer_off_o
        & $past(pin_buffer_off_o)) == 8'h00) else $error("disabled pin reads one");
    a_reset_clears: assert property (disable iff (1'b0) !rstn_i |=>
        {reg_rdata_o, conv_start_o, conv_abort_o, converter_enable_o, pin_buffer_off_o} == '0)
        else $error("outputs not cleared by reset");
endmodule
bind adc_result_and_trigger_ctrl adc_ctrl_properties u_adc_ctrl_properties (.*);

//--- bench/adc_core_model.sv
// Behavioural conversion core answering start requests after a fixed delay.
`timescale 1ns/1ps
module adc_core_model #(
    parameter int LAT = 6
) (
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic       start_i,
    input  wire logic       abort_i,
    input  wire logic [9:0] value_i,
    output logic            done_o = 1'b0,
    output logic [9:0]      result_o = 10'h000,
    output logic            busy_o = 1'b0
);
    int   cnt = 0;
    logic fin;
    assign fin = rstn_i && !abort_i && busy_o && cnt == 1;
    // Result toggles outside the done cycle so a late sample cannot pass.
    always @(posedge clk_i) begin
        done_o <= fin;
        result_o <= fin ? value_i : ~result_o;
        if (!rstn_i || abort_i) begin
            busy_o <= 1'b0;
        end else if (start_i && !busy_o) begin
            cnt <= LAT;
            busy_o <= 1'b1;
        end else if (fin) begin
            busy_o <= 1'b0;
        end else if (busy_o) begin
            cnt <= cnt - 1;
        end
    end
endmodule

//--- bench/adc_result_and_trigger_ctrl_tb_top.sv
// Self-checking bench for the result and trigger block.
`timescale 1ns/1ps
module adc_result_and_trigger_ctrl_tb_top;
    import adc_ctrl_pkg::*;
    logic       clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, kick = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, pin_raw = 8'h5a, pin_off, pin_val;
    logic [9:0] value = 10'h000, result;
    logic [6:0] flags = 7'h00;
    logic       done, busy, start, abort, en, cmp;
    int         n_mismatch = 0, cmp_count = 0, n_start = 0, n_abort = 0, n_done = 0, k;
    // ------------------------------------------------------------
    // Harness
    // ------------------------------------------------------------
    always #50 clk = ~clk;
    always @(posedge clk) begin
        n_start += start;
        n_abort += abort;
        n_done += done;
    end
    adc_result_and_trigger_ctrl u_adc_result_and_trigger_ctrl (
        .core_clk_i(clk), .rstn_i(rstn), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_write_i(wr), .reg_read_i(rd), .reg_rdata_o(rdata), .conv_done_i(done),
        .conv_result_i(result), .conv_busy_i(busy), .conv_start_o(start),
        .conv_abort_o(abort), .converter_enable_o(en), .trigger_flags_i(flags),
        .cmp_neg_from_mux_o(cmp), .pin_raw_i(pin_raw), .pin_buffer_off_o(pin_off),
        .pin_value_o(pin_val));
    adc_core_model u_adc_core_model (.clk_i(clk), .rstn_i(rstn), .start_i(start | kick),
        .abort_i(abort), .value_i(value), .done_o(done), .result_o(result), .busy_o(busy));
    task chk(input logic [9:0] seen, input logic [9:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task wrt(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clk) wr <= 1'b0;
    endtask
    task rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk) {addr, rd} <= {a, 1'b1};
        @(posedge clk) rd <= 1'b0;
        #1 chk({2'b00, rdata}, {2'b00, exp});
    endtask
    task finish_test;
        $display("checks %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // A conversion must finish within a bounded number of cycles.
    task conv(input logic [9:0] v);
        k = n_done;
        @(posedge clk) {value, kick} <= {v, 1'b1};
        @(posedge clk) kick <= 1'b0;
        for (int i = 0; i < 40 && n_done == k; i++) @(posedge clk);
        if (n_done == k) begin
            n_mismatch++;
            finish_test();
        end
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        rdc(OFS_RESULT_LOW, 8'h00);
        rdc(OFS_RESULT_HIGH, 8'h00);
        rdc(OFS_CTRL_B, 8'h00);
        rdc(OFS_PIN_DISABLE, 8'h00);
        rdc(8'h70, 8'h00);
        $display("reset test done");
        wrt(OFS_CTRL_A, 8'h80);
        conv(10'h2a5);
        rdc(OFS_RESULT_LOW, 8'ha5);
        rdc(OFS_RESULT_HIGH, 8'h02);
        wrt(OFS_CHANNEL_SEL, 8'h20);
        rdc(OFS_RESULT_LOW, 8'h40);
        rdc(OFS_RESULT_HIGH, 8'ha9);
        rdc(OFS_RESULT_LOW, 8'h40);
        conv(10'h15a);
        rdc(OFS_RESULT_HIGH, 8'ha9);
        conv(10'h15a);
        rdc(OFS_RESULT_LOW, 8'h80);
        rdc(OFS_RESULT_HIGH, 8'h56);
        conv(10'h3ff);
        rdc(OFS_RESULT_HIGH, 8'hff);
        wrt(OFS_CHANNEL_SEL, 8'h28);
        conv(10'h3f0);
        rdc(OFS_RESULT_LOW, 8'h00);
        rdc(OFS_RESULT_HIGH, 8'hfc);
        $display("result test done");
        wrt(OFS_CTRL_B, 8'hff);
        rdc(OFS_CTRL_B, 8'h47);
        wrt(OFS_CTRL_B, 8'h41);
        chk({9'h000, cmp}, 10'h000);
        wrt(OFS_CTRL_A, 8'h00);
        repeat (2) @(posedge clk);
        chk({9'h000, cmp}, 10'h001);
        wrt(OFS_CTRL_A, 8'h80);
        k = n_start;
        @(posedge clk) flags <= 7'h01;
        repeat (4) @(posedge clk);
        chk(10'(n_start - k), 10'h000);
        $display("control test done");
        wrt(OFS_CTRL_A, 8'ha0);
        for (int c = 1; c < 8; c++) begin
            @(posedge clk) flags <= 7'h00;
            wrt(OFS_CTRL_B, 8'(c));
            k = n_start;
            @(posedge clk) flags <= ~(7'h01 << (c - 1));
            repeat (4) @(posedge clk);
            chk(10'(n_start - k), 10'h000);
            flags <= 7'h7f;
            repeat (4) @(posedge clk);
            chk(10'(n_start - k), 10'h001);
        end
        @(posedge clk) flags <= 7'h02;
        wrt(OFS_CTRL_B, 8'h01);
        k = n_start;
        wrt(OFS_CTRL_B, 8'h02);
        repeat (3) @(posedge clk);
        chk(10'(n_start - k), 10'h001);
        // Selected flag low while the done flag is set: the switch below must still stay quiet.
        @(posedge clk) flags <= 7'h00;
        repeat (10) @(posedge clk);
        k = n_start;
        wrt(OFS_CTRL_B, 8'h00);
        repeat (4) @(posedge clk);
        chk(10'(n_start - k), 10'h000);
        wrt(OFS_CTRL_B, 8'h01);
        @(posedge clk) kick <= 1'b1;
        @(posedge clk) kick <= 1'b0;
        k = n_abort;
        wrt(OFS_CTRL_A, 8'h00);
        repeat (3) @(posedge clk);
        chk(10'(n_abort - k), 10'h001);
        $display("trigger test done");
        wrt(OFS_PIN_DISABLE, 8'h0f);
        repeat (5) @(posedge clk);
        chk({2'b00, pin_val}, {2'b00, 8'h50});
        chk({2'b00, pin_off}, {2'b00, 8'h0f});
        rdc(OFS_PIN_DISABLE, 8'h0f);
        $display("pin test done");
        finish_test();
    end
endmodule
